// ===== hw/fsbp_regs.vh
`ifndef FSBP_REGS_VH
`define FSBP_REGS_VH

// status register field positions
`define FSBP_SR_LOCK 7
`define FSBP_SR_BP3 6
`define FSBP_SR_TB 5
`define FSBP_SR_BP_HI 4
`define FSBP_SR_BP_LO 2
`define FSBP_SR_WEL 1
`define FSBP_SR_WIP 0

// status register power-up value: lock = 1, bottom = 1, no protection
`define FSBP_SR_RESET 8'hA0
`define FSBP_BP_NONE 4'h0
`define FSBP_BP_ALL 4'hB
`define FSBP_BP_STEP 4'h1

// flag status register field positions
`define FSBP_FS_READY 7
`define FSBP_FS_ERASE_ERR 5
`define FSBP_FS_PROG_ERR 4
`define FSBP_FS_PROT_ERR 1
// flag status power-up value: ready, no errors
`define FSBP_FS_RESET 8'h80

// command opcodes
`define FSBP_OP_WREN 8'h06
`define FSBP_OP_WRDI 8'h04
`define FSBP_OP_RDSR 8'h05
`define FSBP_OP_WRSR 8'h01
`define FSBP_OP_RDFSR 8'h70
`define FSBP_OP_CLFSR 8'h50
`define FSBP_OP_PROG 8'h12
`define FSBP_OP_SERASE 8'hDC
`define FSBP_OP_BERASE 8'hC7

// byte counts of a frame, opcode included
`define FSBP_LEN_CMD 3'h1
`define FSBP_LEN_WRSR 3'h2
`define FSBP_LEN_ERASE 3'h5
`define FSBP_LEN_PROG 3'h6
`define FSBP_LEN_MAX 3'h7
`define FSBP_BIT_LAST 3'h7

// array geometry: 1024 sectors of 64KB, byte address 0 .. 03FF_FFFF
`define FSBP_SECT_HI 25
`define FSBP_SECT_LO 16
`define FSBP_NSECT 11'h400

`endif

// ===== hw/fsbp_sync.v
`timescale 1ns/10ps
`include "fsbp_regs.vh"

module fsbp_sync #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // asynchronous inputs and filtered levels
  input wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // three stages; the level moves once stages two and three agree
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          s1_q <= 1'b1;
          s2_q <= 1'b1;
          s3_q <= 1'b1;
          lvl_q <= 1'b1;
        end else begin
          s1_q <= din[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign dout[i] = lvl_q;
    end
  endgenerate

endmodule // fsbp_sync

// ===== hw/fsbp_decode.v
`timescale 1ns/10ps
`include "fsbp_regs.vh"

module fsbp_decode (
  // protect settings
  input wire top_bottom,
  input wire [3:0] block_protect_field,
  // sector under test
  input wire [9:0] sector,
  // decode results
  output reg hit,
  output reg none
);

  reg [10:0] count;

  // sectors covered: none, 1..512 doubling, or all
  always @* begin
    none = (block_protect_field == `FSBP_BP_NONE);
    if (none) begin
      count = 11'h000;
    end else if (block_protect_field >= `FSBP_BP_ALL) begin
      count = `FSBP_NSECT;
    end else begin
      count = 11'h001 << (block_protect_field - `FSBP_BP_STEP);
    end
    // top counts down from 1023, bottom counts up from 0
    if (top_bottom) begin
      hit = ({1'b0, sector} < count);
    end else begin
      hit = ({1'b0, sector} >= (`FSBP_NSECT - count));
    end
  end

endmodule // fsbp_decode

// ===== hw/fsbp_top.v
`timescale 1ns/10ps
`include "fsbp_regs.vh"

module fsbp_top #(
  parameter [15:0] WRSR_CYCLES = 16'h0040,
  parameter [15:0] PROG_CYCLES = 16'h0100,
  parameter [15:0] ERASE_CYCLES = 16'h0400
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // serial link from the host
  input wire sclk,
  input wire cs_n,
  input wire mosi,
  input wire wp_n,
  // serial data out
  output reg miso_q,
  output reg miso_oe_q,
  // observed state
  output reg [7:0] status_q,
  output reg [7:0] flag_status_q,
  output reg busy_q
);

  wire [3:0] pins_s;
  wire sclk_s;
  wire cs_n_s;
  wire mosi_s;
  wire wp_n_s;
  reg sclk_prev_q;
  reg cs_prev_q;
  wire rise;
  wire fall;
  wire frame_end;
  reg [7:0] shift_q;
  reg [2:0] bit_q;
  reg [2:0] nbytes_q;
  reg [7:0] op_q;
  reg [31:0] addr_q;
  reg [7:0] wdata_q;
  reg [7:0] tx_q;
  wire [7:0] byte_v;
  wire byte_done;
  wire [7:0] rd_op;
  reg lock_q;
  reg tb_q;
  reg [3:0] bp_q;
  reg wel_q;
  reg [15:0] busy_cnt_q;
  reg erase_err_q;
  reg prog_err_q;
  reg prot_err_q;
  reg [7:0] status_d;
  reg [7:0] flag_d;
  wire hw_locked;
  wire sect_hit;
  wire bp_none;

  // power-up image, taken apart field by field
  localparam [7:0] SR_INIT = `FSBP_SR_RESET;

  // pins cross into the clock domain
  fsbp_sync #(
    .WIDTH(4)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din({wp_n, mosi, cs_n, sclk}),
    .dout(pins_s)
  );
  assign sclk_s = pins_s[0];
  assign cs_n_s = pins_s[1];
  assign mosi_s = pins_s[2];
  assign wp_n_s = pins_s[3];

  // protect range decode on the addressed sector
  fsbp_decode u_decode (
    .top_bottom(tb_q),
    .block_protect_field(bp_q),
    .sector(addr_q[`FSBP_SECT_HI:`FSBP_SECT_LO]),
    .hit(sect_hit),
    .none(bp_none)
  );

  // link edges and frame end
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclk_prev_q <= 1'b1; // matches the synchroniser preset, no false edge
      cs_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_n_s;
    end
  end
  assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  assign frame_end = cs_n_s & ~cs_prev_q;
  assign byte_v = {shift_q[6:0], mosi_s};
  assign byte_done = rise & (bit_q == `FSBP_BIT_LAST);
  assign rd_op = (nbytes_q == 3'h0) ? byte_v : op_q;

  // status image built from its field positions
  always @* begin
    status_d = 8'h00;
    status_d[`FSBP_SR_LOCK] = lock_q;
    status_d[`FSBP_SR_BP3] = bp_q[3];
    status_d[`FSBP_SR_TB] = tb_q;
    status_d[`FSBP_SR_BP_HI:`FSBP_SR_BP_LO] = bp_q[2:0];
    status_d[`FSBP_SR_WEL] = wel_q;
    status_d[`FSBP_SR_WIP] = busy_q;
  end

  // flag image; ready is the inverse of busy
  always @* begin
    flag_d = 8'h00;
    flag_d[`FSBP_FS_READY] = ~busy_q;
    flag_d[`FSBP_FS_ERASE_ERR] = erase_err_q;
    flag_d[`FSBP_FS_PROG_ERR] = prog_err_q;
    flag_d[`FSBP_FS_PROT_ERR] = prot_err_q;
  end

  // lock bit with write-protect low; no command clears it
  assign hw_locked = lock_q & ~wp_n_s;

  // input shifter, bit and byte counts
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      nbytes_q <= 3'h0;
      op_q <= 8'h00;
      addr_q <= 32'h0000_0000;
      wdata_q <= 8'h00;
    end else if (cs_n_s) begin
      bit_q <= 3'h0;
      nbytes_q <= 3'h0;
    end else if (rise) begin
      shift_q <= byte_v;
      bit_q <= bit_q + 3'h1;
      if (byte_done) begin
        if (nbytes_q != `FSBP_LEN_MAX) begin
          nbytes_q <= nbytes_q + 3'h1;
        end
        if (nbytes_q == 3'h0) begin
          op_q <= byte_v;
        end else if (nbytes_q < `FSBP_LEN_ERASE) begin
          addr_q <= {addr_q[23:0], byte_v};
        end
        if (nbytes_q == 3'h1) begin
          wdata_q <= byte_v;
        end
      end
    end
  end

  // read path: reload each byte, shift out on falling edges
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_q <= 8'h00;
      miso_q <= 1'b0;
      miso_oe_q <= 1'b0;
    end else if (cs_n_s) begin
      miso_oe_q <= 1'b0;
      miso_q <= 1'b0;
    end else if (byte_done) begin
      if (rd_op == `FSBP_OP_RDSR) begin
        tx_q <= status_d;
        miso_oe_q <= 1'b1;
      end else if (rd_op == `FSBP_OP_RDFSR) begin
        tx_q <= flag_d;
        miso_oe_q <= 1'b1;
      end else begin
        tx_q <= 8'h00;
      end
    end else if (fall) begin
      miso_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // command execution at frame end, busy timing
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      lock_q <= SR_INIT[`FSBP_SR_LOCK];
      tb_q <= SR_INIT[`FSBP_SR_TB];
      bp_q <= `FSBP_BP_NONE;
      wel_q <= 1'b0;
      busy_q <= 1'b0;
      busy_cnt_q <= 16'h0000;
      erase_err_q <= 1'b0;
      prog_err_q <= 1'b0;
      prot_err_q <= 1'b0;
    end else if (busy_q) begin
      // operation ends: ready again, latch dropped
      if (busy_cnt_q == 16'h0000) begin
        busy_q <= 1'b0;
        wel_q <= 1'b0;
      end else begin
        busy_cnt_q <= busy_cnt_q - 16'h0001;
      end
    end else if (frame_end) begin
      case (op_q)
        `FSBP_OP_WREN: begin
          if (nbytes_q == `FSBP_LEN_CMD) begin
            wel_q <= 1'b1;
          end
        end
        `FSBP_OP_WRDI: begin
          if (nbytes_q == `FSBP_LEN_CMD) begin
            wel_q <= 1'b0;
          end
        end
        `FSBP_OP_CLFSR: begin
          if (nbytes_q == `FSBP_LEN_CMD) begin
            erase_err_q <= 1'b0;
            prog_err_q <= 1'b0;
            prot_err_q <= 1'b0;
          end
        end
        `FSBP_OP_WRSR: begin
          if (nbytes_q >= `FSBP_LEN_WRSR) begin
            if (wel_q && !hw_locked) begin
              lock_q <= wdata_q[`FSBP_SR_LOCK];
              tb_q <= wdata_q[`FSBP_SR_TB];
              bp_q <= {wdata_q[`FSBP_SR_BP3],
                       wdata_q[`FSBP_SR_BP_HI:`FSBP_SR_BP_LO]};
              busy_q <= 1'b1;
              busy_cnt_q <= WRSR_CYCLES;
            end else begin
              wel_q <= 1'b0;
            end
          end
        end
        `FSBP_OP_PROG: begin
          if ((nbytes_q >= `FSBP_LEN_PROG) && wel_q) begin
            if (sect_hit) begin
              prog_err_q <= 1'b1;
              prot_err_q <= 1'b1;
              wel_q <= 1'b0;
            end else begin
              busy_q <= 1'b1;
              busy_cnt_q <= PROG_CYCLES;
            end
          end
        end
        `FSBP_OP_SERASE: begin
          if ((nbytes_q == `FSBP_LEN_ERASE) && wel_q) begin
            if (sect_hit) begin
              erase_err_q <= 1'b1;
              prot_err_q <= 1'b1;
              wel_q <= 1'b0;
            end else begin
              busy_q <= 1'b1;
              busy_cnt_q <= ERASE_CYCLES;
            end
          end
        end
        `FSBP_OP_BERASE: begin
          if ((nbytes_q == `FSBP_LEN_CMD) && wel_q) begin
            if (!bp_none) begin
              erase_err_q <= 1'b1;
              prot_err_q <= 1'b1;
              wel_q <= 1'b0;
            end else begin
              busy_q <= 1'b1;
              busy_cnt_q <= ERASE_CYCLES;
            end
          end
        end
        default: begin
          wel_q <= wel_q;
        end
      endcase
    end
  end

  // observable copies of the register images
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_q <= SR_INIT; // busy bit clear, matches ready below
      flag_status_q <= `FSBP_FS_RESET;
    end else begin
      status_q <= status_d;
      flag_status_q <= flag_d;
    end
  end

endmodule // fsbp_top

// ===== tb/fsbp_monitor.sv
`timescale 1ns/10ps
module fsbp_monitor #(
  parameter [15:0] WRSR_CYCLES = 16'h0040,
  parameter [15:0] PROG_CYCLES = 16'h0100,
  parameter [15:0] ERASE_CYCLES = 16'h0400
) (
  // clock and reset
  input wire clock,
  input wire resetn,
  // pins
  input wire cs_n,
  input wire wp_n,
  input wire miso_q,
  input wire miso_oe_q,
  // observed state
  input wire [7:0] status_q,
  input wire [7:0] flag_status_q,
  input wire busy_q
);
  reg [15:0] busy_cnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // length of the current busy spell
  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      busy_cnt_q <= 16'h0000;
    else
      busy_cnt_q <= busy_q ? busy_cnt_q + 16'h0001 : 16'h0000;
  end
  AST_WIP_READY: assert property (status_q[0] == !flag_status_q[7])
    else $error("busy bit does not mirror ready bit");
  AST_LOCKED: assert property (!wp_n && $past(wp_n, 8) == 1'b0 && $past(status_q[7])
    |-> $stable(status_q[7:2])) else $error("locked status bits changed");
  AST_OUT_IDLE: assert property (cs_n [*8] |-> !miso_oe_q && !miso_q)
    else $error("data out active while deselected");
  AST_WEL_SET: assert property ($rose(status_q[1]) |-> cs_n)
    else $error("write latch set inside a frame");
  AST_WEL_DROP: assert property ($fell(busy_q) |-> ##[0:2] !status_q[1])
    else $error("write latch kept after operation");
  AST_BUSY_LEN: assert property (busy_cnt_q <= ERASE_CYCLES + 16'h0002)
    else $error("busy lasts too long");
  AST_SR_IN_GAP: assert property ($changed(status_q[7:2]) |-> cs_n)
    else $error("status changed inside a frame");
  AST_PROT_ERR: assert property ($rose(flag_status_q[1])
    |-> !busy_q && (flag_status_q[5] || flag_status_q[4])) else $error("bad protection flag");
endmodule // fsbp_monitor

bind fsbp_top fsbp_monitor #(.WRSR_CYCLES(WRSR_CYCLES), .PROG_CYCLES(PROG_CYCLES),
  .ERASE_CYCLES(ERASE_CYCLES)) fsbp_monitor_inst (.clock(clock), .resetn(resetn),
  .cs_n(cs_n), .wp_n(wp_n), .miso_q(miso_q), .miso_oe_q(miso_oe_q), .status_q(status_q),
  .flag_status_q(flag_status_q), .busy_q(busy_q));

// ===== tb/fsbp_host.sv
`timescale 1ns/10ps
module fsbp_host (
  // link to the device
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire miso_q
);
  logic [7:0] rd_q;
  // idle link: deselected, clock low
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // one frame msb first, read bit caught just before each fall
  task automatic frame(input logic [55:0] d, input int n);
    cs_n <= 1'b0;
    #30;
    for (int i = 0; i < n; i++) begin
      mosi <= d[55-i];
      #24 sclk <= 1'b1;
      #23 rd_q <= {rd_q[6:0], miso_q};
      #1 sclk <= 1'b0;
    end
    #24 cs_n <= 1'b1;
    mosi <= ~mosi; // released line keeps no stale level
    #60;
  endtask
endmodule // fsbp_host

// ===== tb/test_flash_status_block_protection.sv
`timescale 1ns/10ps
module test_flash_status_block_protection;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic wp_n = 1'b1;
  logic [7:0] sr;
  wire sclk, cs_n, mosi, miso_q, miso_oe_q, busy_q;
  wire [7:0] status_q, flag_status_q;
  int miscompares = 0;
  int n_checks = 0;
  int c, e, j;
  // 200 MHz clock
  initial forever #2.5 clock = ~clock;
  fsbp_top #(.WRSR_CYCLES(16'h0010), .PROG_CYCLES(16'h0010), .ERASE_CYCLES(16'h0028))
    fsbp_top_inst (.clock(clock), .resetn(resetn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .wp_n(wp_n), .miso_q(miso_q), .miso_oe_q(miso_oe_q), .status_q(status_q),
    .flag_status_q(flag_status_q), .busy_q(busy_q));
  fsbp_host fsbp_host_inst (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_q(miso_q));
  // compare and count
  task check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // wait out an operation, bounded
  task idle;
    for (int i = 0; i < 400 && busy_q !== 1'b0; i++) @(posedge clock);
    #1;
  endtask
  // latch then status write, read back by command
  task wrsr(input logic [7:0] v);
    fsbp_host_inst.frame({8'h06, 48'h0}, 8);
    fsbp_host_inst.frame({8'h01, v, 40'h0}, 16);
    if (!(sr[7] && !wp_n)) begin
      check({7'h00, busy_q}, 8'h01);
      sr = {v[7:2], 2'b00};
    end
    idle;
    check(status_q, sr);
    fsbp_host_inst.frame({8'h05, 48'h0}, 16);
    check(fsbp_host_inst.rd_q, sr);
  endtask
  // op 0 sector erase, 1 bulk erase, 2 program
  task modify(input logic [9:0] s, input int op);
    int n;
    logic hit;
    c = {sr[6], sr[4:2]};
    n = c == 0 ? 0 : c > 10 ? 1024 : 1 << (c - 1);
    hit = op == 1 ? c != 0 : sr[5] ? s < n : s >= 1024 - n;
    fsbp_host_inst.frame({8'h06, 48'h0}, 8);
    check({7'h00, status_q[1]}, 8'h01);
    fsbp_host_inst.frame({op == 2 ? 8'h12 : op == 1 ? 8'hC7 : 8'hDC, 6'h00, s, 32'h0},
      op == 2 ? 48 : op == 1 ? 8 : 40);
    check(flag_status_q, !hit ? 8'h00 : op == 2 ? 8'h92 : 8'hA2);
    fsbp_host_inst.frame({8'h70, 48'h0}, 16);
    check(fsbp_host_inst.rd_q, !hit ? 8'h80 : op == 2 ? 8'h92 : 8'hA2);
    idle;
    check(status_q, sr);
    fsbp_host_inst.frame({8'h50, 48'h0}, 8);
    check(flag_status_q, 8'h80);
  endtask
  // main sequence
  initial begin
    void'($urandom(49));
    sr = 8'hA0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    repeat (8) @(posedge clock);
    check(status_q, 8'hA0);
    check(flag_status_q, 8'h80);
    fsbp_host_inst.frame({8'h01, 8'h00, 40'h0}, 16);
    check(status_q, sr);
    fsbp_host_inst.frame({8'h06, 48'h0}, 8);
    fsbp_host_inst.frame({8'h04, 48'h0}, 8);
    check(status_q, sr);
    $display("test reset done");
    @(posedge clock) wp_n <= 1'b0;
    wrsr(8'h00);
    @(posedge clock) wp_n <= 1'b1;
    repeat (8) @(posedge clock);
    wrsr(8'h00);
    $display("test lock done");
    for (int k = 0; k < 32; k++) begin
      c = k % 16;
      e = (c >= 1 && c <= 10) ? 1 << (c - 1) : $urandom_range(1023, 0);
      j = k[0] ^ k[3] ^ k[4];
      wrsr({1'b0, c[3], k[4], c[2:0], 2'b00});
      modify(k[4] ? e - 1 + j : 1024 - e - j, k % 8 == 0 ? 1 : k % 8 == 4 ? 2 : 0);
    end
    $display("test protect done");
    test_done;
  end
  // watchdog
  initial begin
    #300000;
    miscompares++;
    test_done;
  end
endmodule // test_flash_status_block_protection
